/* data_space_decode_error_status.sv */
/*
  Data space decoder and sticky error status register of a fixed-point DSP core.
  Assumes X and Y requests arrive from core logic on sys_clk, wait pin from outside.
*/
`timescale 1ns/1ns

// Notes on behaviour
// R01: Status is 16 bits; upper writes ignored
// R02: Low four flags stay set until changed
// R03: Reset loads all zeros into status
// R04: Access only via register transfer path
// R05: Bit 3 marks arithmetic overflow
// R06: Bit 2 marks subroutine stack over/underflow
// R07: Bit 1 marks loop stack over/underflow
// R08: Bit 0 marks prohibited parallel region pairs
// R09: Two independent 64K-word, 16-bit spaces
// R10: Internal X and Y accessible together
// R11: Base variant: first 16K words internal
// R12: ROM variants: first 48K words internal
// R13: Internal range split; ROM/RAM store data
// R14: Software never touches system regions
// R15: External span 48K base, 16K others
// R16: X and Y share bus; select bit
// R17: Wait count register and wait pin stretch
// R18: Select low for X, high for Y
// R19: Partner holds wait low while needed
// R20: Simultaneous errors all set, none lost
module data_space_decode_error_status #(
  parameter dspace_pkg::variant_e VARIANT = dspace_pkg::VAR_BASE
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire dspace_pkg::access_s x_req,
  input  wire dspace_pkg::access_s y_req,
  input  wire logic                alu_overflow,
  input  wire logic                stack_push_full,
  input  wire logic                stack_pop_empty,
  input  wire logic                loop_push_full,
  input  wire logic                loop_pop_empty,
  input  wire logic                esr_wr,
  input  wire logic [15:0]         esr_wdata,
  input  wire logic                wcr_wr,
  input  wire logic [15:0]         wcr_wdata,
  input  wire logic                wait_in_b,
  output dspace_pkg::region_e      x_region,
  output dspace_pkg::region_e      y_region,
  output logic                     x_ram_sel,
  output logic                     y_ram_sel,
  output logic                     x_rom_sel,
  output logic                     y_rom_sel,
  output logic [15:0]              esr_rdata,
  output logic [15:0]              wait_count_rdata,
  output dspace_pkg::ext_bus_s     ext_bus,
  output logic                     stall
);
  import dspace_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic [FLAG_COUNT-1:0] flags;
    logic [15:0]           wait_cnt;
    logic [15:0]           wait_left;
    logic                  ext_busy;
    logic                  ext_y;
    logic                  ext_wr;
    logic [15:0]           ext_addr;
    logic                  wait_s1;
    logic                  wait_s2;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Region decode, shared by both spaces since the maps are identical
  function automatic region_e decode(input logic [15:0] a);
    logic [15:0] ext_start;
    logic [15:0] rom_end;
    logic [15:0] ram_end;
    ext_start = BASE_EXT_START;
    rom_end   = ROM_START;
    ram_end   = BASE_RAM_WORDS;
    case (VARIANT)
      VAR_ROM2K: begin
        ext_start = ROMV_EXT_START;
        rom_end   = ROM2K_ROM_END;
        ram_end   = ROM2K_RAM_END;
      end
      VAR_ROM4K: begin
        ext_start = ROMV_EXT_START;
        rom_end   = ROM4K_ROM_END;
      end
      VAR_ROM12K: begin
        ext_start = ROMV_EXT_START;
        rom_end   = ROM12K_ROM_END;
        ram_end   = ROM12K_RAM_END;
      end
      default: begin
        ext_start = BASE_EXT_START;
      end
    endcase
    if (a >= ext_start)                                    // [R11] [R12] [R15]
      decode = REG_EXTERNAL;
    else if (a < ram_end)
      decode = REG_RAM;                                    // [R13]
    else if (a >= PERIPH_START && a <= PERIPH_END)
      decode = REG_PERIPH;
    else if (a >= ROM_START && a < rom_end)
      decode = REG_ROM;
    else
      decode = REG_SYSTEM;                                 // [R14] undefined data
  endfunction

  logic both;
  logic bad_pair;
  logic start_ext;
  logic ext_y_pick;

  // Independent decoders per space let internal X and Y run together
  always_comb begin
    x_region  = decode(x_req.addr);                        // [R09] [R10]
    y_region  = decode(y_req.addr);
    x_ram_sel = x_req.valid && x_region == REG_RAM;
    y_ram_sel = y_req.valid && y_region == REG_RAM;
    x_rom_sel = x_req.valid && x_region == REG_ROM;
    y_rom_sel = y_req.valid && y_region == REG_ROM;
    both      = x_req.valid && y_req.valid;
    bad_pair  = both && (                                  // [R08]
                (x_region == REG_ROM      && y_region == REG_ROM) ||
                (x_region == REG_ROM      && y_region == REG_EXTERNAL) ||
                (x_region == REG_EXTERNAL && y_region == REG_ROM) ||
                (x_region == REG_EXTERNAL && y_region == REG_EXTERNAL) ||
                (x_region == REG_PERIPH   && y_region == REG_PERIPH));
    ext_y_pick = !(x_req.valid && x_region == REG_EXTERNAL);
    start_ext  = (x_req.valid && x_region == REG_EXTERNAL) ||
                 (y_req.valid && y_region == REG_EXTERNAL);
  end

  // Next-state: flags, wait counter, external cycle
  always_comb begin
    state_next = state_reg;
    state_next.wait_s1 = wait_in_b;
    state_next.wait_s2 = state_reg.wait_s1;
    // Program write first, so hardware sets below override it
    if (esr_wr) begin
      state_next.flags = esr_wdata[FLAG_COUNT-1:0];        // [R01] [R04]
    end
    if (alu_overflow)
      state_next.flags[FLAG_OVERFLOW] = 1'b1;              // [R05] [R20]
    if (stack_push_full || stack_pop_empty)
      state_next.flags[FLAG_STACK] = 1'b1;                 // [R06] [R20]
    if (loop_push_full || loop_pop_empty)
      state_next.flags[FLAG_LOOPSTACK] = 1'b1;             // [R07] [R20]
    if (bad_pair)
      state_next.flags[FLAG_BUSACCESS] = 1'b1;             // [R08] [R20]
    if (wcr_wr)
      state_next.wait_cnt = wcr_wdata;
    // External cycle: counted waits, then pin waits while held low
    if (state_reg.ext_busy) begin
      if (state_reg.wait_left != 16'h0000)
        state_next.wait_left = state_reg.wait_left - 16'h0001;    // [R17]
      else if (state_reg.wait_s2)
        state_next.ext_busy = 1'b0;                        // [R17] [R19]
    end else if (start_ext) begin
      state_next.ext_busy  = 1'b1;
      state_next.wait_left = state_reg.wait_cnt;
      state_next.ext_y     = ext_y_pick;                   // [R16] [R18]
      state_next.ext_wr    = ext_y_pick ? y_req.write : x_req.write;
      state_next.ext_addr  = ext_y_pick ? y_req.addr : x_req.addr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg          <= '0;
      state_reg.flags    <= ESR_RESET[FLAG_COUNT-1:0];     // [R03]
      state_reg.wait_cnt <= WAIT_RESET;
      state_reg.wait_s1  <= 1'b1;
      state_reg.wait_s2  <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Register reads; upper status bits read as zero
  always_comb begin
    esr_rdata        = {{(ESR_WIDTH-FLAG_COUNT){1'b0}}, state_reg.flags}; // [R01] [R02]
    wait_count_rdata = state_reg.wait_cnt;
    ext_bus.active   = state_reg.ext_busy;
    ext_bus.space_y  = state_reg.ext_y;                    // [R18]
    ext_bus.read_n   = !(state_reg.ext_busy && !state_reg.ext_wr);
    ext_bus.write_n  = !(state_reg.ext_busy && state_reg.ext_wr);
    ext_bus.addr     = state_reg.ext_addr;
    stall            = state_reg.ext_busy && (state_reg.wait_left != 16'h0000 ||
                       !state_reg.wait_s2);
  end

  AST_OVF_SETS: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R05]
    alu_overflow |=> esr_rdata[3]) else $error("overflow flag not set");
  AST_STACK_SETS: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R06]
    (stack_push_full || stack_pop_empty) |=> esr_rdata[2]) else $error("stack flag not set");
  AST_LOOP_SETS: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R07]
    (loop_push_full || loop_pop_empty) |=> esr_rdata[1]) else $error("loop flag not set");
  AST_BAC_ROMROM: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R08]
    (both && x_region == REG_ROM && y_region == REG_ROM) |=> esr_rdata[0])
    else $error("bus access flag missed");
  AST_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R02]
    (esr_rdata[3] && !esr_wr) |=> esr_rdata[3]) else $error("flag dropped");
  AST_UPPER_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R01]
    esr_rdata[15:4] == 12'h000) else $error("upper bits not zero");
  AST_WRITE_LOADS: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R04]
    (esr_wr && !alu_overflow) |=> esr_rdata[3] == $past(esr_wdata[3]))
    else $error("write not stored");
  AST_EXT_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    (VARIANT == VAR_BASE && x_req.addr >= 16'h4000) |-> x_region == REG_EXTERNAL)
    else $error("external decode wrong");
  AST_SEL_Y: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R18]
    (!ext_bus.active && !x_req.valid && y_req.valid && y_region == REG_EXTERNAL)
    |=> ext_bus.space_y) else $error("space select wrong");

  // Reset must leave every flag clear at the first edge after release
  AST_RESET_FLAGS: assert property (@(posedge sys_clk) // [R03]
    $rose(rst_b) |-> esr_rdata == 16'h0000) else $error("flags not clear after reset");

  // Bus must come out of reset idle, both strobes high
  AST_RESET_BUS: assert property (@(posedge sys_clk) // [R16]
    $rose(rst_b) |-> (!ext_bus.active && ext_bus.read_n && ext_bus.write_n))
    else $error("bus not idle after reset");

  // ROM paired with external space is refused
  AST_BAC_ROMEXT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R08]
    (both && x_region == REG_ROM && y_region == REG_EXTERNAL) |=> esr_rdata[0])
    else $error("bus access flag missed");

  // External paired with ROM, the mirror case
  AST_BAC_EXTROM: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R08]
    (both && x_region == REG_EXTERNAL && y_region == REG_ROM) |=> esr_rdata[0])
    else $error("bus access flag missed");

  // Both spaces on the one shared bus at once
  AST_BAC_EXTEXT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R08]
    (both && x_region == REG_EXTERNAL && y_region == REG_EXTERNAL) |=> esr_rdata[0])
    else $error("bus access flag missed");

  // Peripheral area has a single port
  AST_BAC_PERPER: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R08]
    (both && x_region == REG_PERIPH && y_region == REG_PERIPH) |=> esr_rdata[0])
    else $error("bus access flag missed");

  // Internal RAM pair is legal and must not raise the flag
  AST_RAM_PAIR_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
    (both && x_region == REG_RAM && y_region == REG_RAM && !esr_rdata[0] && !esr_wr)
    |=> !esr_rdata[0]) else $error("legal pair flagged");

  // Stack flag holds without a program write
  AST_STICKY_STACK: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R02]
    (esr_rdata[2] && !esr_wr) |=> esr_rdata[2]) else $error("flag dropped");

  // Loop stack flag holds without a program write
  AST_STICKY_LOOP: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R02]
    (esr_rdata[1] && !esr_wr) |=> esr_rdata[1]) else $error("flag dropped");

  // Bus access flag holds without a program write
  AST_STICKY_BAC: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R02]
    (esr_rdata[0] && !esr_wr) |=> esr_rdata[0]) else $error("flag dropped");

  // Program write lands in the stack flag when no event competes
  AST_WRITE_STACK: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R04]
    (esr_wr && !stack_push_full && !stack_pop_empty) |=> esr_rdata[2] == $past(esr_wdata[2]))
    else $error("write not stored");

  // Program write lands in the loop flag when no event competes
  AST_WRITE_LOOP: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R04]
    (esr_wr && !loop_push_full && !loop_pop_empty) |=> esr_rdata[1] == $past(esr_wdata[1]))
    else $error("write not stored");

  // Program write lands in the bus flag when no pair is refused
  AST_WRITE_BAC: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R04]
    (esr_wr && !bad_pair) |=> esr_rdata[0] == $past(esr_wdata[0]))
    else $error("write not stored");

  // A clearing write must not swallow an error of the same cycle
  AST_SET_OVER_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R20]
    (esr_wr && alu_overflow) |=> esr_rdata[3]) else $error("error lost to write");

  // Y space uses the same map as X
  AST_EXT_DECODE_Y: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    (VARIANT == VAR_BASE && y_req.addr >= 16'h4000) |-> y_region == REG_EXTERNAL)
    else $error("external decode wrong");

  // Base variant keeps the low quarter internal
  AST_INT_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    (VARIANT == VAR_BASE && x_req.addr < 16'h4000) |-> x_region != REG_EXTERNAL)
    else $error("internal decode wrong");

  // ROM variants move the external start to the top quarter
  AST_ROMV_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R12] [R15]
    (VARIANT != VAR_BASE) |-> ((x_req.addr >= 16'hC000) == (x_region == REG_EXTERNAL)))
    else $error("variant decode wrong");

  // Peripheral window is the same in every variant
  AST_PERIPH_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R13]
    (x_req.addr >= PERIPH_START && x_req.addr <= PERIPH_END) |-> x_region == REG_PERIPH)
    else $error("peripheral decode wrong");

  // X accesses drive the select low
  AST_SEL_X: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R18]
    (!ext_bus.active && x_req.valid && x_region == REG_EXTERNAL)
    |=> !ext_bus.space_y) else $error("space select wrong");

  // An idle bus accepts a valid external request
  AST_START_EXT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
    (!ext_bus.active && start_ext) |=> ext_bus.active) else $error("cycle not started");

  // Address must not move while the cycle is stretched
  AST_ADDR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16] [R17]
    (ext_bus.active && stall) |=> (ext_bus.active && $stable(ext_bus.addr)))
    else $error("address moved in wait");

  // Exactly one strobe low during a cycle
  AST_ONE_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
    ext_bus.active |-> (ext_bus.read_n != ext_bus.write_n)) else $error("strobe clash");

  // Strobes stay high between cycles
  AST_IDLE_STROBES: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
    !ext_bus.active |-> (ext_bus.read_n && ext_bus.write_n)) else $error("strobe while idle");

  // Wait count register takes the written value
  AST_WCR_LOADS: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R17]
    wcr_wr |=> wait_count_rdata == $past(wcr_wdata)) else $error("wait count not stored");

  // A nonzero wait count stretches the first cycle
  AST_SOFT_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R17]
    (!ext_bus.active && start_ext && wait_count_rdata != 16'h0000) |=> stall)
    else $error("no soft wait");

  // Stall only ever comes from a running external cycle
  AST_STALL_BUSY: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R17]
    stall |-> ext_bus.active) else $error("stall while idle");

endmodule // data_space_decode_error_status

/* dspace_pkg.sv */
/*
  Shared constants and carriers for the data space decoder and error status block.
  Assumes a single core clock domain and that the core supplies decoded access requests.
*/
package dspace_pkg;

  // Error status register layout
  localparam int          ESR_WIDTH       = 16;
  localparam int          FLAG_OVERFLOW   = 3;
  localparam int          FLAG_STACK      = 2;
  localparam int          FLAG_LOOPSTACK  = 1;
  localparam int          FLAG_BUSACCESS  = 0;
  localparam int          FLAG_COUNT      = 4;
  localparam logic [15:0] ESR_RESET       = 16'h0000;

  // Address map (word addresses)
  localparam logic [15:0] BASE_EXT_START  = 16'h4000;
  localparam logic [15:0] ROMV_EXT_START  = 16'hC000;
  localparam logic [15:0] PERIPH_START    = 16'h3800;
  localparam logic [15:0] PERIPH_END      = 16'h383F;
  localparam logic [15:0] ROM_START       = 16'h4000;
  localparam logic [15:0] BASE_RAM_WORDS  = 16'h0800;
  localparam logic [15:0] WAIT_RESET      = 16'h0000;
  localparam logic [15:0] ROM2K_ROM_END   = 16'h4800;
  localparam logic [15:0] ROM2K_RAM_END   = 16'h0400;
  localparam logic [15:0] ROM4K_ROM_END   = 16'h5000;
  localparam logic [15:0] ROM12K_ROM_END  = 16'h7000;
  localparam logic [15:0] ROM12K_RAM_END  = 16'h0C00;

  // Variant selection
  typedef enum logic [1:0] {
    VAR_BASE,
    VAR_ROM2K,
    VAR_ROM4K,
    VAR_ROM12K
  } variant_e;

  // Decoded region of one access
  typedef enum logic [2:0] {
    REG_RAM,
    REG_ROM,
    REG_PERIPH,
    REG_SYSTEM,
    REG_EXTERNAL
  } region_e;

  // One data space access request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } access_s;

  // External bus outputs
  typedef struct packed {
    logic        active;
    logic        space_y;
    logic        read_n;
    logic        write_n;
    logic [15:0] addr;
  } ext_bus_s;

endpackage

/* dspace_ext_mem.sv */
/*
  External data memory model on the shared bus, driving the wait pin.
  Assumes the bus active flag and a stretch length supplied by the bench.
*/
`timescale 1ns/1ns
module dspace_ext_mem (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       active,
  input  wire logic [3:0] hold,
  output logic            wait_in_b
);
  logic [3:0] cnt_reg;

  // Cycles spent in the current bus cycle, saturating so long holds never wrap
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= active ? cnt_reg + 4'(cnt_reg != 4'hF) : 4'h0;
    end
  end

  // Slow memory: pin low for the first hold cycles of each access
  assign wait_in_b = !(active && (cnt_reg < hold));
endmodule // dspace_ext_mem

/* tb_data_space_decode_error_status.sv */
/*
  Self-checking bench for the data space decoder and error status register.
  Assumes the base variant and the slow-memory model on the wait pin.
*/
`timescale 1ns/1ns
module tb_data_space_decode_error_status;
  import dspace_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        rst_b     = 1'b0;
  access_s     x_req     = '0;
  access_s     y_req     = '0;
  logic [4:0]  ev        = 5'h00;
  logic        esr_wr    = 1'b0;
  logic        wcr_wr    = 1'b0;
  logic [15:0] esr_wdata = 16'h0000;
  logic [15:0] wcr_wdata = 16'h0000;
  logic [3:0]  hold      = 4'h0;
  logic        wait_in_b, x_ram_sel, y_ram_sel, x_rom_sel, y_rom_sel, stall;
  region_e     x_region, y_region;
  logic [15:0] esr_rdata, wait_count_rdata;
  ext_bus_s    ext_bus;
  int          n_fail = 0, check_count = 0, cyc = 0, n = 0;
  logic [15:0] adr [9] = '{16'h0000, 16'h07FF, 16'h0800, 16'h3800, 16'h383F,
                           16'h3840, 16'h3FFF, 16'h4000, 16'hFFFF};
  region_e     rgn [9] = '{REG_RAM, REG_RAM, REG_SYSTEM, REG_PERIPH, REG_PERIPH,
                           REG_SYSTEM, REG_SYSTEM, REG_EXTERNAL, REG_EXTERNAL};
  region_e     rgy [9] = '{REG_SYSTEM, REG_PERIPH, REG_SYSTEM, REG_RAM, REG_RAM,
                           REG_RAM, REG_RAM, REG_SYSTEM, REG_RAM};
  logic [3:0]  evx [5] = '{4'h2, 4'h2, 4'h4, 4'h4, 4'h8};

  data_space_decode_error_status dut (.sys_clk(sys_clk), .rst_b(rst_b), .x_req(x_req),
    .y_req(y_req), .alu_overflow(ev[4]), .stack_push_full(ev[3]), .stack_pop_empty(ev[2]),
    .loop_push_full(ev[1]), .loop_pop_empty(ev[0]), .esr_wr(esr_wr), .esr_wdata(esr_wdata),
    .wcr_wr(wcr_wr), .wcr_wdata(wcr_wdata), .wait_in_b(wait_in_b), .x_region(x_region),
    .y_region(y_region), .x_ram_sel(x_ram_sel), .y_ram_sel(y_ram_sel), .x_rom_sel(x_rom_sel),
    .y_rom_sel(y_rom_sel), .esr_rdata(esr_rdata), .wait_count_rdata(wait_count_rdata),
    .ext_bus(ext_bus), .stall(stall));
  dspace_ext_mem mem (.sys_clk(sys_clk), .rst_b(rst_b), .active(ext_bus.active),
    .hold(hold), .wait_in_b(wait_in_b));

  // Clock and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // Transfer-path write, optionally with events landing on the same edge
  task automatic write_esr(logic [15:0] d, logic [4:0] e);
    esr_wdata = d;
    esr_wr = 1'b1;
    ev = e;
    tick(1);
    esr_wr = 1'b0;
    ev = 5'h00;
    tick(1);
  endtask
  // One external access, then count the cycles the bus stays busy
  task automatic ext_access(logic sp, logic wr, logic [15:0] a);
    if (sp) y_req = '{1'b1, wr, a};
    else x_req = '{1'b1, wr, a};
    tick(1);
    x_req = '0;
    y_req = '0;
    check("space", 16'(ext_bus.space_y), 16'(sp));
    check("strobes", 16'({ext_bus.write_n, ext_bus.read_n}), wr ? 16'h1 : 16'h2);
    check("bus addr", ext_bus.addr, a);
    check("stall", 16'(stall), 16'(wcr_wdata != 16'h0000));
    for (n = 0; ext_bus.active === 1'b1 && n < 64; n++) tick(1);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence: reset, flags, decode, parallel pairs, bus stretching
  initial begin
    tick(20);
    rst_b = 1'b1;
    tick(1);
    check("esr reset", esr_rdata, ESR_RESET);
    check("wait reset", wait_count_rdata, WAIT_RESET);
    for (int i = 0; i < 5; i++) begin
      write_esr(16'h0000, 5'h00);
      ev = 5'(1 << i);
      tick(1);
      ev = 5'h00;
      tick(4);
      check("event flag", 16'(esr_rdata[3:0]), 16'(evx[i]));
    end
    write_esr(16'hFFF5, 5'h00);
    check("esr write", 16'(esr_rdata[3:0]), 16'h5);
    write_esr(16'h0000, 5'h15);
    check("set over clear", 16'(esr_rdata[3:0]), 16'hE);
    for (int i = 0; i < 9; i++) begin
      x_req.addr = adr[i];
      y_req.addr = ~adr[i] & 16'h3FFF;
      #1 check("x region", 16'(x_region), 16'(rgn[i]));
      check("y region", 16'(y_region), 16'(rgy[i]));
    end
    // Parallel pairs: ext/ext and periph/periph flag, internal RAM pair does not
    for (int i = 0; i < 4; i++) begin
      write_esr(16'h0000, 5'h00);
      x_req = '{1'b1, 1'b0, adr[i == 0 ? 7 : (i == 1 ? 3 : 0)]};
      y_req = '{1'b1, 1'b0, i == 0 ? 16'h8000 : (i == 1 ? 16'h383F : 16'h07FF)};
      #1 check("ram pair sel", 16'({x_ram_sel, y_ram_sel}), i > 1 ? 16'h3 : 16'h0);
      check("rom sel", 16'({x_rom_sel, y_rom_sel}), 16'h0);
      // Requests stay clear of system areas; pair stands for one edge
      tick(1);
      x_req = '0;
      y_req = '0;
      tick(3);
      check("bus access flag", 16'(esr_rdata[0]), 16'(i < 2));
    end
    ext_access(1'b1, 1'b0, 16'hC000);
    check("no wait cycle", 16'(n), 16'h1);
    ext_access(1'b0, 1'b1, 16'h4001);
    check("write cycle", 16'(n), 16'h1);
    wcr_wdata = 16'h0003;
    wcr_wr = 1'b1;
    tick(1);
    wcr_wr = 1'b0;
    check("wait count", wait_count_rdata, 16'h0003);
    ext_access(1'b1, 1'b0, 16'h9000);
    check("soft wait", 16'(n), 16'h4);
    hold = 4'h8;
    ext_access(1'b1, 1'b1, 16'hA000);
    check("pin wait", 16'(n > 8), 16'h1);
    wrap_up();
  end
endmodule // tb_data_space_decode_error_status
